//--- counter_array_pkg.sv
// Shared constants for the counter array block: register map, field
// positions, reset values, timebase codes and divider counts.
// Assumes a 32-bit APB slave with byte addresses below 0x40.
package counter_array_pkg;
   localparam int ADDR_W = 8;
   localparam int NUM_CHAN = 3;
   // Register byte addresses
   localparam logic [7:0] OFS_CNT_LOW = 8'h00;
   localparam logic [7:0] OFS_CNT_HIGH = 8'h04;
   localparam logic [7:0] OFS_MODE = 8'h08;
   localparam logic [7:0] OFS_FLAGS = 8'h0c;
   localparam logic [7:0] OFS_CFG = 8'h10;
   localparam logic [7:0] OFS_CHAN_BASE = 8'h20;
   localparam logic [7:0] OFS_CHAN_STRIDE = 8'h08;
   localparam logic [7:0] OFS_CHAN_VALUE = 8'h04;
   // counter_mode_reg fields
   localparam int MODE_IDLE_SUSPEND = 7;
   localparam int MODE_WATCHDOG = 6;
   localparam int MODE_SEL_LSB = 1;
   localparam int MODE_OVF_IRQ_EN = 0;
   localparam logic [7:0] MODE_RESET = 8'h40;
   // Flag register fields
   localparam int FLAG_COUNTER_OVF = 7;
   localparam int FLAG_INTERMEDIATE = 6;
   // Config register fields
   localparam int CFG_INT_IRQ_EN = 2;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // Channel mode fields
   localparam int CH_IRQ_EN = 0;
   localparam int CH_CAP_NEG = 1;
   localparam int CH_CAP_POS = 2;
   localparam int CH_MATCH = 3;
   localparam int CH_TOGGLE = 4;
   localparam int CH_COMPARE = 5;
   localparam logic [7:0] CH_MODE_RESET = 8'h00;
   localparam logic [15:0] CH_VALUE_RESET = 16'h0000;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam int WDT_CHAN = 2;
   // Timebase codes
   localparam logic [2:0] TB_DIV12 = 3'b000;
   localparam logic [2:0] TB_DIV4 = 3'b001;
   localparam logic [2:0] TB_T0_OVF = 3'b010;
   localparam logic [2:0] TB_EXT_IN = 3'b011;
   localparam logic [2:0] TB_SYSCLK = 3'b100;
   localparam logic [2:0] TB_EXT_OSC = 3'b101;
   localparam logic [2:0] TB_RTC_OSC = 3'b110;
   localparam logic [2:0] TB_RESERVED = 3'b111;
   // Divider counts
   localparam int DIV_SLOW = 12;
   localparam int DIV_FAST = 4;
   localparam int DIV_OSC = 8;
endpackage

//--- timebase_if.sv
// Carries the timebase selection to the source generator and the
// one-cycle advance tick back. Single clock domain.
`timescale 1ns/1ps
interface timebase_if;
   logic [2:0] select;
   logic tick;
   modport counter_side (output select, input tick);
   modport source_side (input select, output tick);
endinterface

//--- timebase_gen.sv
// Timebase source generator: dividers, oscillator synchronisers and the
// rate-limited external count input. Inputs are sampled on clk_i.
`timescale 1ns/1ps
module timebase_gen
   import counter_array_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic t0_ovf_i,
   input wire logic ext_count_i,
   input wire logic ext_osc_i,
   input wire logic rtc_osc_i,
   timebase_if.source_side tb
);
   logic [3:0] div_slow;
   logic [1:0] div_fast;
   logic en_slow, en_fast;
   logic [1:0] ext_sync, rtc_sync;
   logic ext_last, rtc_last;
   logic [2:0] ext_div, rtc_div;
   logic ext_tick, rtc_tick;
   logic eci_sample;

   assign en_slow = (div_slow == 4'(DIV_SLOW - 1));
   assign en_fast = (div_fast == 2'(DIV_FAST - 1));

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_slow <= '0;
         div_fast <= '0;
      end else begin
         div_slow <= en_slow ? 4'h0 : div_slow + 4'h1;
         div_fast <= div_fast + 2'h1;
      end
   end

   // Oscillators pass two flops before any edge logic
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ext_sync <= '0;
         rtc_sync <= '0;
         ext_last <= 1'b0;
         rtc_last <= 1'b0;
         ext_div <= '0;
         rtc_div <= '0;
      end else begin
         ext_sync <= {ext_sync[0], ext_osc_i};
         rtc_sync <= {rtc_sync[0], rtc_osc_i};
         ext_last <= ext_sync[1];
         rtc_last <= rtc_sync[1];
         if (ext_sync[1] && !ext_last)
            ext_div <= ext_div + 3'h1;
         if (rtc_sync[1] && !rtc_last)
            rtc_div <= rtc_div + 3'h1;
      end
   end

   // Divide by 8: one tick per 8 rising edges
   assign ext_tick = ext_sync[1] && !ext_last && (ext_div == 3'(DIV_OSC - 1));
   assign rtc_tick = rtc_sync[1] && !rtc_last && (rtc_div == 3'(DIV_OSC - 1));

   // External input sampled at sysclk/4, so falls count at most that fast
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         eci_sample <= 1'b1;
      else if (en_fast)
         eci_sample <= ext_count_i;
   end

   always_comb begin
      case (tb.select)
         TB_DIV12: tb.tick = en_slow;
         TB_DIV4: tb.tick = en_fast;
         TB_SYSCLK: tb.tick = 1'b1;
         TB_T0_OVF: tb.tick = t0_ovf_i;
         TB_EXT_IN: tb.tick = en_fast && eci_sample && !ext_count_i;
         TB_EXT_OSC: tb.tick = ext_tick;
         TB_RTC_OSC: tb.tick = rtc_tick;
         default: tb.tick = 1'b0;
      endcase
   end
endmodule

//--- counter_array.sv
// Counter array core: shared 16-bit counter, snapshot read, overflow
// flags, three capture/compare channels and the combined interrupt.
// Assumes an APB master on CLOCK_I and synchronous inputs.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module counter_array
   import counter_array_pkg::*;
(
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic CPU_IDLE_I,
   input wire logic TIMER0_OVF_I,
   input wire logic EXT_COUNT_I,
   input wire logic EXT_OSC_I,
   input wire logic RTC_OSC_I,
   input wire logic [NUM_CHAN-1:0] CHAN_IO_I,
   output logic [NUM_CHAN-1:0] CHAN_IO_O,
   output logic [NUM_CHAN-1:0] CHAN_IO_OE_N_O,
   output logic WATCHDOG_MODE_O,
   output logic IRQ_O
);
   timebase_if tb();

   logic [15:0] count;
   logic [7:0] snapshot;
   logic [7:0] mode_reg;
   logic [7:0] cfg_reg;
   logic counter_overflow_flag;
   logic intermediate_overflow_flag;
   logic [NUM_CHAN-1:0] channel_event_flag;
   logic [7:0] chan_mode [NUM_CHAN];
   logic [15:0] chan_value [NUM_CHAN];
   logic [NUM_CHAN-1:0] chan_out;
   logic [NUM_CHAN-1:0] chan_in_last;
   logic [NUM_CHAN-1:0] chan_hit;
   logic setup_rd, access_wr;
   logic advance, wraps, mid_wraps;
   logic [15:0] next_count;
   logic cnt_wr, flag_wr;
   logic [31:0] next_rdata;
   logic next_err;

   function automatic logic chan_sel(input logic [7:0] addr, input int n,
                                     input logic [7:0] ofs);
      chan_sel = (addr == 8'(OFS_CHAN_BASE + OFS_CHAN_STRIDE * n + ofs));
   endfunction

   function automatic logic low_bits_full(input logic [15:0] v, input logic [1:0] sel);
      case (sel)
         2'h0: low_bits_full = &v[7:0];
         2'h1: low_bits_full = &v[8:0];
         2'h2: low_bits_full = &v[9:0];
         default: low_bits_full = &v[10:0];
      endcase
   endfunction

   timebase_gen u_timebase (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .t0_ovf_i(TIMER0_OVF_I),
      .ext_count_i(EXT_COUNT_I),
      .ext_osc_i(EXT_OSC_I),
      .rtc_osc_i(RTC_OSC_I),
      .tb(tb.source_side)
   );

   assign tb.select = mode_reg[MODE_SEL_LSB+2:MODE_SEL_LSB];
   assign WATCHDOG_MODE_O = mode_reg[MODE_WATCHDOG];

   // APB: zero wait states, data prepared in the setup cycle
   assign setup_rd = PSEL_I && !PENABLE_I && !PWRITE_I;
   assign access_wr = PSEL_I && PENABLE_I && PWRITE_I;
   assign PREADY_O = 1'b1;
   assign cnt_wr = access_wr && !mode_reg[MODE_WATCHDOG] &&
                   (PADDR_I == OFS_CNT_LOW || PADDR_I == OFS_CNT_HIGH);
   assign flag_wr = access_wr && PADDR_I == OFS_FLAGS;

   // Counter advance; idle suspend only gates while the core idles
   assign advance = tb.tick && !(mode_reg[MODE_IDLE_SUSPEND] && CPU_IDLE_I);
   assign next_count = count + 16'h0001;
   assign wraps = advance && count == CNT_MAX;
   assign mid_wraps = advance && low_bits_full(count, cfg_reg[1:0]);

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I)
         count <= CNT_RESET;
      else if (cnt_wr && PADDR_I == OFS_CNT_LOW)
         count <= {count[15:8], PWDATA_I[7:0]};
      else if (cnt_wr)
         count <= {PWDATA_I[7:0], count[7:0]};
      else if (advance)
         count <= next_count;
   end

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I)
         snapshot <= 8'h00;
      else if (setup_rd && PADDR_I == OFS_CNT_LOW)
         snapshot <= count[15:8];
   end

   // Watchdog on after reset; while on, only the watchdog bit is writable
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I)
         mode_reg <= MODE_RESET;
      else if (access_wr && PADDR_I == OFS_MODE) begin
         if (mode_reg[MODE_WATCHDOG])
            mode_reg[MODE_WATCHDOG] <= PWDATA_I[MODE_WATCHDOG];
         else
            mode_reg <= PWDATA_I[7:0];
      end
   end

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I)
         cfg_reg <= CFG_RESET;
      else if (access_wr && PADDR_I == OFS_CFG)
         cfg_reg <= PWDATA_I[7:0];
   end

   // Flags: write 0 clears, write 1 keeps; a set in the same cycle wins
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         counter_overflow_flag <= 1'b0;
         intermediate_overflow_flag <= 1'b0;
      end else begin
         if (wraps)
            counter_overflow_flag <= 1'b1;
         else if (flag_wr && !PWDATA_I[FLAG_COUNTER_OVF])
            counter_overflow_flag <= 1'b0;
         if (mid_wraps)
            intermediate_overflow_flag <= 1'b1;
         else if (flag_wr && !PWDATA_I[FLAG_INTERMEDIATE])
            intermediate_overflow_flag <= 1'b0;
      end
   end

   generate
      for (genvar n = 0; n < NUM_CHAN; n++) begin : g_chan
         logic locked;
         logic rise, fall, cap, match;
         assign locked = (n == WDT_CHAN) && mode_reg[MODE_WATCHDOG];
         assign rise = CHAN_IO_I[n] && !chan_in_last[n];
         assign fall = !CHAN_IO_I[n] && chan_in_last[n];
         assign cap = (rise && chan_mode[n][CH_CAP_POS]) ||
                      (fall && chan_mode[n][CH_CAP_NEG]);
         assign match = advance && chan_mode[n][CH_COMPARE] && next_count == chan_value[n];
         assign chan_hit[n] = cap || (match && chan_mode[n][CH_MATCH]);

         always_ff @(posedge CLOCK_I or posedge RST_I) begin
            if (RST_I) begin
               chan_mode[n] <= CH_MODE_RESET;
               chan_value[n] <= CH_VALUE_RESET;
               chan_in_last[n] <= 1'b0;
               chan_out[n] <= 1'b0;
               channel_event_flag[n] <= 1'b0;
            end else begin
               chan_in_last[n] <= CHAN_IO_I[n];
               if (access_wr && !locked && chan_sel(PADDR_I, n, 8'h00))
                  chan_mode[n] <= PWDATA_I[7:0];
               if (cap)
                  chan_value[n] <= count;
               else if (access_wr && !locked && chan_sel(PADDR_I, n, OFS_CHAN_VALUE))
                  chan_value[n] <= PWDATA_I[15:0];
               if (match && chan_mode[n][CH_TOGGLE])
                  chan_out[n] <= !chan_out[n];
               if (chan_hit[n])
                  channel_event_flag[n] <= 1'b1;
               else if (flag_wr && !PWDATA_I[n])
                  channel_event_flag[n] <= 1'b0;
            end
         end
         assign CHAN_IO_OE_N_O[n] = !chan_mode[n][CH_TOGGLE];
      end
   endgenerate

   assign CHAN_IO_O = chan_out;

   // Combined request: each flag gated by its own enable
   assign IRQ_O = (counter_overflow_flag && mode_reg[MODE_OVF_IRQ_EN]) ||
                  (intermediate_overflow_flag && cfg_reg[CFG_INT_IRQ_EN]) ||
                  (|(channel_event_flag & {chan_mode[2][CH_IRQ_EN],
                                           chan_mode[1][CH_IRQ_EN],
                                           chan_mode[0][CH_IRQ_EN]}));

   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      case (PADDR_I)
         OFS_CNT_LOW: next_rdata[7:0] = count[7:0];
         OFS_CNT_HIGH: next_rdata[7:0] = snapshot;
         OFS_MODE: next_rdata[7:0] = mode_reg;
         OFS_CFG: next_rdata[7:0] = cfg_reg;
         OFS_FLAGS: next_rdata[7:0] = {counter_overflow_flag, intermediate_overflow_flag,
                                       3'b000, channel_event_flag};
         default: begin
            next_err = 1'b1;
            for (int i = 0; i < NUM_CHAN; i++) begin
               if (chan_sel(PADDR_I, i, 8'h00)) begin
                  next_rdata[7:0] = chan_mode[i];
                  next_err = 1'b0;
               end
               if (chan_sel(PADDR_I, i, OFS_CHAN_VALUE)) begin
                  next_rdata[15:0] = chan_value[i];
                  next_err = 1'b0;
               end
            end
         end
      endcase
   end

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         PRDATA_O <= 32'h0000_0000;
         PSLVERR_O <= 1'b0;
      end else if (PSEL_I && !PENABLE_I) begin
         PRDATA_O <= PWRITE_I ? 32'h0000_0000 : next_rdata;
         PSLVERR_O <= next_err;
      end else if (!PSEL_I) begin
         PSLVERR_O <= 1'b0;
      end
   end

   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);

   sequence s_low_read;
      setup_rd && PADDR_I == OFS_CNT_LOW;
   endsequence

   property p_snapshot;
      s_low_read |=> snapshot == $past(count[15:8]);
   endproperty
   a_snapshot: assert property (p_snapshot) else $error("snapshot mismatch");

   property p_wrap;
      (advance && count == CNT_MAX && !cnt_wr) |=> count == CNT_RESET && counter_overflow_flag;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap did not set flag");

   property p_reserved;
      (tb.select == TB_RESERVED && !cnt_wr) |=> count == $past(count);
   endproperty
   a_reserved: assert property (p_reserved) else $error("counted on reserved");

   property p_idle_hold;
      (mode_reg[MODE_IDLE_SUSPEND] && CPU_IDLE_I && !cnt_wr) |=> count == $past(count);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("counted in idle");

   property p_read_no_effect;
      (setup_rd && tb.tick && !CPU_IDLE_I && !cnt_wr) |=> count == $past(count) + 16'h0001;
   endproperty
   a_read_no_effect: assert property (p_read_no_effect) else $error("read stalled count");

   // Cycles since the last divide-by-12 tick, saturating at 15
   logic [3:0] div12_gap;

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I)
         div12_gap <= 4'hf;
      else if (tb.tick && tb.select == TB_DIV12)
         div12_gap <= 4'h0;
      else if (div12_gap != 4'hf)
         div12_gap <= div12_gap + 4'h1;
   end

   property p_div12;
      (tb.tick && tb.select == TB_DIV12) |-> div12_gap >= 4'(DIV_SLOW - 1);
   endproperty
   a_div12: assert property (p_div12) else $error("div12 tick spacing");

   property p_sticky;
      (counter_overflow_flag && !flag_wr) |=> counter_overflow_flag;
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped alone");

   property p_irq_gate;
      (counter_overflow_flag && mode_reg[MODE_OVF_IRQ_EN]) |-> IRQ_O;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq missing");

   property p_mid;
      (advance && cfg_reg[1:0] == 2'h0 && count[7:0] == 8'hff) |=> intermediate_overflow_flag;
   endproperty
   a_mid: assert property (p_mid) else $error("intermediate flag missing");

   property p_wdt_lock;
      (mode_reg[MODE_WATCHDOG] && access_wr && chan_sel(PADDR_I, WDT_CHAN, 8'h00))
         |=> chan_mode[WDT_CHAN] == $past(chan_mode[WDT_CHAN]);
   endproperty
   a_wdt_lock: assert property (p_wdt_lock) else $error("watchdog channel written");

   property p_wdt_count;
      (mode_reg[MODE_WATCHDOG] && access_wr && !advance &&
       (PADDR_I == OFS_CNT_LOW || PADDR_I == OFS_CNT_HIGH)) |=> count == $past(count);
   endproperty
   a_wdt_count: assert property (p_wdt_count) else $error("counter written in watchdog");

   property p_chan_flag;
      chan_hit != '0 |=> (channel_event_flag & $past(chan_hit)) == $past(chan_hit);
   endproperty
   a_chan_flag: assert property (p_chan_flag) else $error("channel flag not set");

   property p_irq_quiet;
      (channel_event_flag == '0 && !counter_overflow_flag && !intermediate_overflow_flag)
         |-> !IRQ_O;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("irq without a flag");

   property p_ovf_clear;
      (flag_wr && !PWDATA_I[FLAG_COUNTER_OVF] && !wraps) |=> !counter_overflow_flag;
   endproperty
   a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

   property p_sysclk;
      tb.select == TB_SYSCLK |-> tb.tick;
   endproperty
   a_sysclk: assert property (p_sysclk) else $error("sysclk tick missing");

   property p_reserved_tick;
      tb.select == TB_RESERVED |-> !tb.tick;
   endproperty
   a_reserved_tick: assert property (p_reserved_tick) else $error("tick on reserved");
endmodule

//--- counter_array_tb.sv
// Self-checking bench for the counter array: APB master, timebase stimulus,
// flag, interrupt, channel and watchdog-lock scenarios.
// Assumes zero-wait APB with read data loaded at the setup edge.
`timescale 1ns/1ps
module counter_array_tb
   import counter_array_pkg::*;
;
   typedef struct {logic [31:0] v; logic err; logic [1:0] kind;} note_t;
   logic clk, rst, psel, pen, pwr, idle, t0, ext, eosc, rosc, pready, pslverr, wdm, irq;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, seed;
   logic [2:0] chin, chout, choe;
   logic [7:0] prev;
   note_t q[$];
   note_t n;
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;
   int np;
   int tab[8] = '{4, 12, 0, 2, 48, 1, 1, 0};

   counter_array i_counter_array (.CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .CPU_IDLE_I(idle), .TIMER0_OVF_I(t0),
      .EXT_COUNT_I(ext), .EXT_OSC_I(eosc), .RTC_OSC_I(rosc), .CHAN_IO_I(chin),
      .CHAN_IO_O(chout), .CHAN_IO_OE_N_O(choe), .WATCHDOG_MODE_O(wdm), .IRQ_O(irq));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // Kind: 0 exact data, 1 low-byte step since last read, 2 reference, 3 error only
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] k, input logic e);
      q.push_back('{v: d, err: e, kind: k});
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   // Two low reads 48 cycles apart with source activity in between
   task automatic step(input logic [2:0] code, input logic susp, input logic [31:0] exp);
      xfer(1'b1, OFS_MODE, {24'h000000, susp, 3'b000, code, 1'b0}, 2'd3, 1'b0);
      xfer(1'b0, OFS_CNT_LOW, 32'h0, 2'd2, 1'b0);
      for (int i = 0; i < 45; i++) begin
         @(posedge clk);
         t0 <= (code == TB_T0_OVF) && i >= 4 && i < 4 + 2 * np && (i % 2 == 0);
         ext <= !((i >= 8 && i < 16) || (i >= 24 && i < 32));
         eosc <= (code == TB_EXT_OSC) && i >= 4 && i < 36 && i[1];
         rosc <= (code == TB_RTC_OSC) && i >= 4 && i < 36 && i[1];
      end
      xfer(1'b0, OFS_CNT_LOW, exp, 2'd1, 1'b0);
   endtask

   task automatic see_irq(input logic exp);
      @(posedge clk);
      check("irq", {31'd0, irq}, {31'd0, exp});
   endtask

   always @(posedge clk) begin
      if (psel === 1'b1 && pen === 1'b1 && pready === 1'b1) begin
         if (q.size() == 0) begin
            check("note queue", 32'd1, 32'd0);
         end else begin
            n = q.pop_front();
            check("pslverr", {31'd0, pslverr}, {31'd0, n.err});
            if (n.kind == 2'd0) check("read data", prdata, n.v);
            if (n.kind == 2'd1) check("count step", {24'd0, prdata[7:0] - prev}, n.v);
            if (n.kind != 2'd3) prev = prdata[7:0];
         end
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles > 5000) begin
         n_fail++;
         wrap_up();
      end
   end

   initial begin
      {psel, pen, pwr, t0, eosc, rosc} = '0;
      chin = '0;
      paddr = '0;
      pwdata = '0;
      ext = 1'b1;
      idle = 1'b0;
      rst = 1'b1;
      seed = 32'd83;
      prev = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("watchdog after reset", {31'd0, wdm}, 32'd1);
      xfer(1'b0, OFS_MODE, {24'd0, MODE_RESET}, 2'd0, 1'b0);
      xfer(1'b0, 8'h14, 32'h0, 2'd3, 1'b1);
      xfer(1'b1, 8'h38, 32'hff, 2'd3, 1'b1);
      xfer(1'b1, OFS_MODE, 32'h4f, 2'd3, 1'b0);
      xfer(1'b0, OFS_MODE, 32'h40, 2'd0, 1'b0);
      xfer(1'b1, OFS_MODE, 32'h00, 2'd3, 1'b0);
      xfer(1'b0, OFS_MODE, 32'h00, 2'd0, 1'b0);
      // All timebase codes while the processor idles
      idle <= 1'b1;
      for (int c = 0; c < 8; c++) begin
         seed = xs(seed);
         np = int'(seed[2:0]) + 1;
         step(c[2:0], 1'b0, (c == 2) ? 32'(np) : 32'(tab[c]));
      end
      step(TB_SYSCLK, 1'b1, 32'd0);
      idle <= 1'b0;
      step(TB_SYSCLK, 1'b1, 32'd48);
      // Snapshot and overflow
      xfer(1'b1, OFS_MODE, 32'h0e, 2'd3, 1'b0);
      xfer(1'b1, OFS_FLAGS, 32'h0, 2'd3, 1'b0);
      xfer(1'b1, OFS_CNT_LOW, 32'hf0, 2'd3, 1'b0);
      xfer(1'b1, OFS_CNT_HIGH, 32'h12, 2'd3, 1'b0);
      xfer(1'b0, OFS_CNT_LOW, 32'hf0, 2'd0, 1'b0);
      xfer(1'b1, OFS_CNT_HIGH, 32'hff, 2'd3, 1'b0);
      xfer(1'b0, OFS_CNT_HIGH, 32'h12, 2'd0, 1'b0);
      xfer(1'b0, OFS_CNT_LOW, 32'hf0, 2'd0, 1'b0);
      xfer(1'b0, OFS_CNT_HIGH, 32'hff, 2'd0, 1'b0);
      xfer(1'b0, OFS_FLAGS, 32'h0, 2'd0, 1'b0);
      xfer(1'b1, OFS_CFG, 32'h07, 2'd3, 1'b0);
      xfer(1'b1, OFS_MODE, 32'h09, 2'd3, 1'b0);
      repeat (30) @(posedge clk);
      see_irq(1'b1);
      xfer(1'b1, OFS_MODE, 32'h0e, 2'd3, 1'b0);
      xfer(1'b0, OFS_FLAGS, 32'hc0, 2'd0, 1'b0);
      see_irq(1'b1);
      xfer(1'b1, OFS_CFG, 32'h03, 2'd3, 1'b0);
      see_irq(1'b0);
      xfer(1'b0, OFS_FLAGS, 32'hc0, 2'd0, 1'b0);
      xfer(1'b1, OFS_FLAGS, 32'h7f, 2'd3, 1'b0);
      xfer(1'b0, OFS_FLAGS, 32'h40, 2'd0, 1'b0);
      // Channel match, toggle and capture
      xfer(1'b1, OFS_FLAGS, 32'h0, 2'd3, 1'b0);
      xfer(1'b1, OFS_CNT_LOW, 32'h0, 2'd3, 1'b0);
      xfer(1'b1, OFS_CNT_HIGH, 32'h0, 2'd3, 1'b0);
      xfer(1'b1, 8'h20, 32'h29, 2'd3, 1'b0);
      xfer(1'b1, 8'h24, 32'h05, 2'd3, 1'b0);
      xfer(1'b1, 8'h28, 32'h38, 2'd3, 1'b0);
      xfer(1'b1, 8'h2c, 32'h03, 2'd3, 1'b0);
      xfer(1'b1, OFS_MODE, 32'h08, 2'd3, 1'b0);
      repeat (20) @(posedge clk);
      xfer(1'b1, OFS_MODE, 32'h0e, 2'd3, 1'b0);
      xfer(1'b0, OFS_FLAGS, 32'h03, 2'd0, 1'b0);
      see_irq(1'b1);
      check("line out", {29'd0, chout}, 32'h2);
      check("line enable", {29'd0, choe}, 32'h5);
      xfer(1'b1, OFS_CNT_LOW, 32'h34, 2'd3, 1'b0);
      xfer(1'b1, OFS_CNT_HIGH, 32'h12, 2'd3, 1'b0);
      xfer(1'b1, 8'h30, 32'h04, 2'd3, 1'b0);
      chin <= 3'b100;
      repeat (4) @(posedge clk);
      xfer(1'b0, 8'h34, 32'h1234, 2'd0, 1'b0);
      xfer(1'b0, OFS_FLAGS, 32'h07, 2'd0, 1'b0);
      // Watchdog lock, counter held on the reserved code
      xfer(1'b1, OFS_MODE, 32'h4e, 2'd3, 1'b0);
      xfer(1'b1, 8'h30, 32'h00, 2'd3, 1'b0);
      xfer(1'b0, 8'h30, 32'h04, 2'd0, 1'b0);
      xfer(1'b1, OFS_CNT_LOW, 32'h00, 2'd3, 1'b0);
      xfer(1'b0, OFS_CNT_LOW, 32'h34, 2'd0, 1'b0);
      see_irq(1'b1);
      wrap_up();
   end
endmodule
